// File: design/fbrg_pkg.sv
package fbrg_pkg;

    // Register map, one byte per register
    localparam int FBRG_ADDR_W = 6;
    localparam logic [5:0] FBRG_OFS_CTRL_ONE = 6'h04;
    localparam logic [5:0] FBRG_OFS_CTRL_TWO = 6'h0C;
    localparam int FBRG_BIT_EMPTY_EN = 4;
    localparam int FBRG_BIT_SAFE_EN = 7;
    localparam logic [7:0] FBRG_RST_CTRL_ONE = 8'h00;
    localparam logic [7:0] FBRG_RST_CTRL_TWO = 8'h20;
    localparam logic [7:0] FBRG_RD_UNMAPPED = 8'h00;

    // Frame-buffer read command: opcode bits compared under a mask
    localparam logic [7:0] FBRG_CMD_MASK = 8'hE0;
    localparam logic [7:0] FBRG_CMD_FB_READ = 8'h20;

    // Link bit count per byte
    localparam logic [2:0] FBRG_LAST_BIT = 3'h7;

    // Timing: empty flag settles 750 ns after the command byte
    localparam int FBRG_CLK_MHZ = 100;
    localparam int FBRG_T12_NS = 750;
    localparam int FBRG_T12_CYC = (FBRG_T12_NS * FBRG_CLK_MHZ + 999) / 1000;
    // Core edges spent in the byte-event crossing before the count starts
    localparam int FBRG_SYNC_CYC = 4;
    localparam logic [6:0] FBRG_WAIT_LAST = 7'(FBRG_T12_CYC - FBRG_SYNC_CYC - 1);

    localparam logic [7:0] FBRG_CNT_ONE = 8'h01;
    localparam logic [6:0] FBRG_T_ONE = 7'h01;

    typedef enum logic [1:0] {
        FBRG_ST_OTHER,
        FBRG_ST_RX_BASIC,
        FBRG_ST_RX_AACK
    } fbrg_trx_state_t;

    typedef enum logic [1:0] {
        FBRG_M_IDLE,
        FBRG_M_BUSY,
        FBRG_M_WAIT,
        FBRG_M_FLAG
    } fbrg_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } fbrg_reg_req_t;

    typedef struct packed {
        logic frame_start;
        logic byte_wr;
        logic fcs_ok;
        logic frame_done_event;
        logic error;
    } fbrg_rx_ev_t;

endpackage

// File: design/fbrg_top.sv
`timescale 1ns/1ps
// What this block does
// RL1: Enabled indicator turns interrupt pin into empty flag
// RL2: Flag low means more bytes may be read
// RL3: Flag high when no unread byte; host pauses
// RL4: Flag valid only 750 ns after command
// RL5: Select release shows pending interrupts immediately
// RL6: Other accesses carry interrupts only
// RL7: Interrupts suppressed while pin is flag
// RL8: Receive error locks flag high for access
// RL9: Host aborts when flag high over 64 us
// RL10: Flag ignores interrupt polarity setting
// RL11: Control one bit 4 enables indicator
// RL12: Unprotected receiver overwrites buffer with new frames
// RL13: Protected frame blocks new radio writes
// RL14: Protect on good checksum or frame-done event
// RL15: Protection only when enabled and receiving
// RL16: Host buffer writes always pass
// RL17: Control two bit 7 enables protection
// RL18: Release on read end or receive exit
// RL19: Protection independent of detection threshold
// RL20: Empty when read count meets written count
module fbrg_top
    import fbrg_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic spi_sclk,
    input wire logic spi_sel_n,
    input wire logic spi_mosi,
    input wire fbrg_pkg::fbrg_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire fbrg_pkg::fbrg_trx_state_t trx_state,
    input wire fbrg_pkg::fbrg_rx_ev_t rx,
    input wire logic host_fb_wr,
    input wire logic irq_in,
    output logic irq_pin,
    output logic fb_radio_we,
    output logic fb_host_we
);
    import fbrg_pkg::*;

    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [7:0] shreg;
        logic [7:0] cmd;
        logic first_done;
        logic tgl;
    } fbrg_lnk_t;

    typedef struct packed {
        logic sel_s1;
        logic sel_s2;
        logic sel_s3;
        logic tgl_s1;
        logic tgl_s2;
        logic tgl_s3;
        logic tgl_s4;
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic [7:0] rdata;
        fbrg_mode_t mode;
        logic in_fb;
        logic [6:0] t_cnt;
        logic [7:0] rd_cnt;
        logic [7:0] wr_cnt;
        logic err_lock;
        logic prot;
        fbrg_trx_state_t last_state;
        logic irq_pin;
    } fbrg_core_t;

    fbrg_lnk_t lk;
    fbrg_lnk_t next_lk;
    fbrg_core_t cs;
    fbrg_core_t next_cs;

    logic sel_rise;
    logic byte_evt;
    logic cmd_match;
    logic prot_arm;
    logic prot_release;
    logic radio_ok;
    logic buf_empty;

    function automatic logic is_rx(input fbrg_trx_state_t st);
        return (st == FBRG_ST_RX_BASIC) || (st == FBRG_ST_RX_AACK);
    endfunction

    function automatic logic [7:0] reg_read(input logic [5:0] a, input fbrg_core_t c);
        if (a == FBRG_OFS_CTRL_ONE) begin
            return c.ctrl_one;
        end else if (a == FBRG_OFS_CTRL_TWO) begin
            return c.ctrl_two;
        end
        return FBRG_RD_UNMAPPED;
    endfunction

    // Link side: shift the host bytes on the serial clock. Select high
    // clears it, since the host stops the clock between accesses.
    always_comb begin
        next_lk = lk;
        next_lk.shreg = {lk.shreg[6:0], spi_mosi};
        next_lk.bit_cnt = lk.bit_cnt + 3'h1;
        if (lk.bit_cnt == FBRG_LAST_BIT) begin
            next_lk.tgl = ~lk.tgl; // One toggle per whole byte
            if (!lk.first_done) begin
                next_lk.cmd = {lk.shreg[6:0], spi_mosi};
                next_lk.first_done = 1'b1;
            end
        end
    end

    always_ff @(posedge spi_sclk or posedge spi_sel_n) begin
        if (spi_sel_n) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // Toggle is taken from the third and fourth stages while select reads low, so the
    // toggle clear at select release can never pass for a byte.
    assign sel_rise = cs.sel_s2 & ~cs.sel_s3;
    assign byte_evt = (cs.tgl_s3 ^ cs.tgl_s4) & ~cs.sel_s2;
    // Command byte is frozen once captured, so it is stable when read here
    assign cmd_match = (lk.cmd & FBRG_CMD_MASK) == FBRG_CMD_FB_READ;

    // Protection arming and release; threshold settings play no part
    always_comb begin
        prot_arm = 1'b0; // see RL19
        if (cs.ctrl_two[FBRG_BIT_SAFE_EN] && is_rx(trx_state)) begin // see RL15, RL17
            if (trx_state == FBRG_ST_RX_AACK) begin
                prot_arm = rx.frame_done_event; // see RL14
            end else begin
                prot_arm = rx.fcs_ok; // see RL14
            end
        end
        prot_release = (sel_rise & cs.in_fb) // see RL18
            | (trx_state != cs.last_state)
            | ~is_rx(trx_state)
            | ~cs.ctrl_two[FBRG_BIT_SAFE_EN];
    end

    assign radio_ok = ~cs.prot;
    assign buf_empty = cs.err_lock | (cs.rd_cnt >= cs.wr_cnt); // see RL20, RL8

    // Buffer write strobes: only the radio path is gated
    assign fb_radio_we = rx.byte_wr & radio_ok; // see RL13, RL12
    assign fb_host_we = host_fb_wr; // see RL16

    // Core state update
    always_comb begin
        next_cs = cs;
        next_cs.sel_s1 = spi_sel_n;
        next_cs.sel_s2 = cs.sel_s1;
        next_cs.sel_s3 = cs.sel_s2;
        next_cs.tgl_s1 = lk.tgl;
        next_cs.tgl_s2 = cs.tgl_s1;
        next_cs.tgl_s3 = cs.tgl_s2;
        next_cs.tgl_s4 = cs.tgl_s3;
        next_cs.last_state = trx_state;

        // Register port
        if (reg_req.wr && reg_req.addr == FBRG_OFS_CTRL_ONE) begin
            next_cs.ctrl_one = reg_req.wdata; // see RL11
        end
        if (reg_req.wr && reg_req.addr == FBRG_OFS_CTRL_TWO) begin
            next_cs.ctrl_two = reg_req.wdata; // see RL17
        end
        if (reg_req.rd) begin
            next_cs.rdata = reg_read(reg_req.addr, cs);
        end

        // Receiver fill count of the current frame
        if (radio_ok && rx.frame_start) begin
            next_cs.wr_cnt = '0; // see RL12
        end else if (radio_ok && rx.byte_wr) begin
            next_cs.wr_cnt = cs.wr_cnt + FBRG_CNT_ONE;
        end

        // Arming wins over a release in the same cycle
        next_cs.prot = prot_arm | (cs.prot & ~prot_release); // see RL13, RL18

        // Access sequencing
        if (sel_rise) begin
            next_cs.mode = FBRG_M_IDLE; // see RL5
            next_cs.in_fb = 1'b0;
            next_cs.rd_cnt = '0;
            next_cs.err_lock = 1'b0;
            next_cs.t_cnt = '0;
        end else begin
            case (cs.mode)
                FBRG_M_IDLE: begin
                    if (byte_evt && cmd_match) begin
                        next_cs.in_fb = 1'b1;
                        if (cs.ctrl_one[FBRG_BIT_EMPTY_EN]) begin
                            next_cs.mode = FBRG_M_WAIT; // see RL1
                        end else begin
                            next_cs.mode = FBRG_M_BUSY; // see RL6
                        end
                    end else if (byte_evt) begin
                        next_cs.mode = FBRG_M_BUSY;
                    end
                end
                FBRG_M_BUSY: begin
                    if (byte_evt && cs.in_fb) begin
                        next_cs.rd_cnt = cs.rd_cnt + FBRG_CNT_ONE;
                    end
                end
                FBRG_M_WAIT: begin
                    next_cs.t_cnt = cs.t_cnt + FBRG_T_ONE;
                    if (cs.t_cnt == FBRG_WAIT_LAST) begin
                        next_cs.mode = FBRG_M_FLAG; // see RL4
                    end
                    if (rx.error) begin
                        next_cs.err_lock = 1'b1; // see RL8
                    end
                end
                FBRG_M_FLAG: begin
                    if (byte_evt) begin
                        next_cs.rd_cnt = cs.rd_cnt + FBRG_CNT_ONE; // see RL2
                    end
                    if (rx.error) begin
                        next_cs.err_lock = 1'b1; // see RL8
                    end
                end
                default: begin
                    next_cs.mode = FBRG_M_IDLE;
                end
            endcase
        end

        // Pin: interrupt level, or the polarity-free empty flag
        case (cs.mode)
            FBRG_M_WAIT: next_cs.irq_pin = 1'b1; // see RL4, RL7
            FBRG_M_FLAG: next_cs.irq_pin = buf_empty; // see RL3, RL7, RL10
            default: next_cs.irq_pin = irq_in; // see RL6, RL5
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cs <= '0;
            cs.sel_s1 <= 1'b1;
            cs.sel_s2 <= 1'b1;
            cs.sel_s3 <= 1'b1;
            cs.ctrl_one <= FBRG_RST_CTRL_ONE; // see RL11
            cs.ctrl_two <= FBRG_RST_CTRL_TWO; // see RL17
            cs.mode <= FBRG_M_IDLE;
            cs.last_state <= FBRG_ST_OTHER;
        end else begin
            cs <= next_cs;
        end
    end

    assign irq_pin = cs.irq_pin;
    assign reg_rdata = cs.rdata;

    // Checks on the pin, the protection and the strobes
    chk_irq_passthru: assert property (@(posedge core_clk) disable iff (srst) // see RL6
        (cs.mode == FBRG_M_IDLE || cs.mode == FBRG_M_BUSY) |=> (irq_pin == $past(irq_in)))
        else $error("interrupt pin does not follow interrupt level");

    chk_empty_high: assert property (@(posedge core_clk) disable iff (srst) // see RL3
        (cs.mode == FBRG_M_FLAG && cs.rd_cnt >= cs.wr_cnt) |=> irq_pin)
        else $error("empty flag low with no unread byte");

    chk_flag_low_data: assert property (@(posedge core_clk) disable iff (srst) // see RL2
        (cs.mode == FBRG_M_FLAG && !cs.err_lock && cs.rd_cnt < cs.wr_cnt) |=> !irq_pin)
        else $error("empty flag high with unread byte");

    chk_err_lock_high: assert property (@(posedge core_clk) disable iff (srst) // see RL8
        (cs.err_lock && cs.mode == FBRG_M_FLAG) |=> irq_pin)
        else $error("error lock did not hold flag high");

    chk_wait_span: assert property (@(posedge core_clk) disable iff (srst) // see RL4
        (cs.mode == FBRG_M_IDLE && byte_evt && cmd_match && !sel_rise
            && cs.ctrl_one[FBRG_BIT_EMPTY_EN])
        |=> (cs.mode == FBRG_M_WAIT && !sel_rise)[*8] ##0 irq_pin)
        else $error("flag settled before its latency");

    chk_sel_release: assert property (@(posedge core_clk) disable iff (srst) // see RL18
        (sel_rise && cs.in_fb && !prot_arm) |=> !cs.prot)
        else $error("protection kept after read end");

    chk_radio_block: assert property (@(posedge core_clk) disable iff (srst) // see RL13
        (cs.prot && rx.byte_wr) |-> !fb_radio_we)
        else $error("radio write passed while protected");

    chk_host_write: assert property (@(posedge core_clk) disable iff (srst) // see RL16
        host_fb_wr |-> fb_host_we)
        else $error("host buffer write blocked");

    chk_rx_leave: assert property (@(posedge core_clk) disable iff (srst) // see RL15
        (!is_rx(trx_state)) |=> !cs.prot)
        else $error("protection held outside receive");

    chk_arm_basic: assert property (@(posedge core_clk) disable iff (srst) // see RL14
        (cs.ctrl_two[FBRG_BIT_SAFE_EN] && trx_state == FBRG_ST_RX_BASIC && rx.fcs_ok)
        |=> cs.prot)
        else $error("good frame not protected");

    chk_arm_aack: assert property (@(posedge core_clk) disable iff (srst) // see RL14
        (cs.ctrl_two[FBRG_BIT_SAFE_EN] && trx_state == FBRG_ST_RX_AACK && rx.frame_done_event)
        |=> cs.prot)
        else $error("ended frame not protected");

    chk_safe_off: assert property (@(posedge core_clk) disable iff (srst) // see RL17
        (!cs.ctrl_two[FBRG_BIT_SAFE_EN]) |=> !cs.prot)
        else $error("protection held with enable cleared");

    chk_state_change: assert property (@(posedge core_clk) disable iff (srst) // see RL18
        (cs.prot && trx_state != cs.last_state && !prot_arm) |=> !cs.prot)
        else $error("protection kept across a state change");

    // Radio strobe and fill count while unprotected or protected
    chk_radio_pass: assert property (@(posedge core_clk) disable iff (srst) // see RL12
        (!cs.prot && rx.byte_wr) |-> fb_radio_we)
        else $error("radio write blocked while unprotected");

    chk_count_frozen: assert property (@(posedge core_clk) disable iff (srst) // see RL13
        (cs.prot && (rx.byte_wr || rx.frame_start)) |=> (cs.wr_cnt == $past(cs.wr_cnt)))
        else $error("fill count moved while protected");

    // Register writes land on the next edge
    chk_reg_one: assert property (@(posedge core_clk) disable iff (srst) // see RL11
        (reg_req.wr && reg_req.addr == FBRG_OFS_CTRL_ONE)
        |=> (cs.ctrl_one == $past(reg_req.wdata)))
        else $error("control one write lost");

    chk_reg_two: assert property (@(posedge core_clk) disable iff (srst) // see RL17
        (reg_req.wr && reg_req.addr == FBRG_OFS_CTRL_TWO)
        |=> (cs.ctrl_two == $past(reg_req.wdata)))
        else $error("control two write lost");

    // Access sequencing: command decode, latency count and select release
    chk_enter_wait: assert property (@(posedge core_clk) disable iff (srst) // see RL1
        (cs.mode == FBRG_M_IDLE && byte_evt && cmd_match && !sel_rise
            && cs.ctrl_one[FBRG_BIT_EMPTY_EN]) |=> (cs.mode == FBRG_M_WAIT))
        else $error("frame read did not start the indicator");

    chk_no_indicator: assert property (@(posedge core_clk) disable iff (srst) // see RL6
        (cs.mode == FBRG_M_IDLE && byte_evt && cmd_match && !sel_rise
            && !cs.ctrl_one[FBRG_BIT_EMPTY_EN]) |=> (cs.mode == FBRG_M_BUSY))
        else $error("indicator started while disabled");

    chk_wait_high: assert property (@(posedge core_clk) disable iff (srst) // see RL7
        (cs.mode == FBRG_M_WAIT) |=> irq_pin)
        else $error("pin low during flag latency");

    chk_wait_hold: assert property (@(posedge core_clk) disable iff (srst) // see RL4
        (cs.mode == FBRG_M_WAIT && !sel_rise && cs.t_cnt != FBRG_WAIT_LAST)
        |=> (cs.mode == FBRG_M_WAIT))
        else $error("flag latency cut short");

    chk_wait_end: assert property (@(posedge core_clk) disable iff (srst) // see RL4
        (cs.mode == FBRG_M_WAIT && !sel_rise && cs.t_cnt == FBRG_WAIT_LAST)
        |=> (cs.mode == FBRG_M_FLAG))
        else $error("flag latency overran");

    chk_flag_follow: assert property (@(posedge core_clk) disable iff (srst) // see RL10
        (cs.mode == FBRG_M_FLAG) |=> (irq_pin == $past(buf_empty)))
        else $error("pin does not carry the empty flag");

    chk_err_sets: assert property (@(posedge core_clk) disable iff (srst) // see RL8
        (rx.error && !sel_rise && (cs.mode == FBRG_M_WAIT || cs.mode == FBRG_M_FLAG))
        |=> cs.err_lock)
        else $error("receive error did not lock the flag");

    // Select release ends the access and clears all of its state
    chk_sel_idle: assert property (@(posedge core_clk) disable iff (srst) // see RL5
        sel_rise |=> (cs.mode == FBRG_M_IDLE))
        else $error("access kept after select release");

    chk_sel_clear: assert property (@(posedge core_clk) disable iff (srst) // see RL8
        sel_rise |=> (!cs.err_lock && cs.rd_cnt == '0 && !cs.in_fb))
        else $error("access state kept after select release");

endmodule

// File: tb/fbrg_host_model.sv
`timescale 1ns/1ps
// Host end of the serial link; its clock runs only inside accesses
module fbrg_host_model (
    output logic spi_sclk,
    output logic spi_sel_n,
    output logic spi_mosi,
    input wire logic irq_pin
);
    initial begin
        spi_sclk = 1'b0;
        spi_sel_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // MSB first at a 15 ns period, then the minimum byte gap
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = b[i];
            #7.5 spi_sclk = 1'b1;
            #7.5 spi_sclk = 1'b0;
        end
        #250;
    endtask
    // Flag is not trusted until 750 ns after the command byte
    task automatic begin_access(input logic [7:0] cmd);
        spi_sel_n = 1'b0;
        #20;
        send_byte(cmd);
        #500;
    endtask
    // Stall while the flag is high; give up after 64 us to avoid a deadlock
    task automatic read_byte(output logic ok);
        int t;
        t = 0;
        while (irq_pin !== 1'b0 && t < 6400) begin
            #10;
            t++;
        end
        ok = (t < 6400);
        if (ok) begin
            send_byte(8'h00);
        end
    endtask
    // A released data line shows the inverse of its last bit
    task automatic end_access();
        #250 spi_sel_n = 1'b1;
        spi_mosi = ~spi_mosi;
        #250;
    endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import fbrg_pkg::*;
    typedef struct packed {
        logic [1:0] src;
        logic [7:0] v;
    } fbrg_note_t;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic irq_in = 1'b0;
    logic host_fb_wr = 1'b0;
    logic look = 1'b0;
    logic spi_sclk, spi_sel_n, spi_mosi, irq_pin, fb_radio_we, fb_host_we, ok;
    logic [7:0] reg_rdata;
    fbrg_reg_req_t reg_req = '0;
    fbrg_trx_state_t trx_state = FBRG_ST_OTHER;
    fbrg_rx_ev_t rx = '0;
    fbrg_note_t notes[$];
    int fail_count = 0;
    int checks = 0;
    int seed;

    always #5 core_clk = ~core_clk;

    fbrg_top u_dut (.core_clk(core_clk), .srst(srst), .spi_sclk(spi_sclk),
        .spi_sel_n(spi_sel_n), .spi_mosi(spi_mosi), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .trx_state(trx_state), .rx(rx), .host_fb_wr(host_fb_wr), .irq_in(irq_in),
        .irq_pin(irq_pin), .fb_radio_we(fb_radio_we), .fb_host_we(fb_host_we));
    fbrg_host_model u_host (.spi_sclk(spi_sclk), .spi_sel_n(spi_sel_n), .spi_mosi(spi_mosi),
        .irq_pin(irq_pin));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Monitor: oldest note against the output it names, at the quiet edge
    always @(negedge core_clk) begin
        fbrg_note_t n;
        if (look && notes.size() > 0) begin
            n = notes.pop_front();
            check(n.src == 2'h0 ? reg_rdata : {7'h00, n.src == 2'h1 ? irq_pin :
                n.src == 2'h2 ? fb_radio_we : fb_host_we}, n.v);
        end
    end

    // Two edges per note so no pulse is assigned twice in one step
    task automatic note(input logic [1:0] src, input logic [7:0] v);
        notes.push_back({src, v});
        look <= 1'b1;
        @(posedge core_clk);
        look <= 1'b0;
        rx <= '0;
        host_fb_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic pulse(input fbrg_rx_ev_t ev);
        rx <= ev;
        @(posedge core_clk);
        rx <= '0;
        @(posedge core_clk);
    endtask
    task automatic radio(input logic [7:0] e);
        rx.byte_wr <= 1'b1;
        note(2'h2, e);
    endtask
    task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk);
        reg_req <= '0;
        @(posedge core_clk);
    endtask
    task automatic reg_rd(input logic [5:0] a, input logic [7:0] e);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk);
        reg_req <= '0;
        note(2'h0, e);
    endtask
    task automatic wrap_up();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog well past the 64 us stall of the locked-flag case
    initial begin
        #500000;
        fail_count++;
        wrap_up();
    end

    initial begin
        seed = $urandom(32'h1c5b8f9e);
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        reg_rd(6'h04, 8'h00);
        reg_rd(6'h0C, 8'h20);
        reg_rd(6'h3F, 8'h00);
        reg_wr(6'h04, 8'h10);
        reg_rd(6'h04, 8'h10);
        $display("test registers done");
        // A non-read access keeps the pin on the interrupt path
        u_host.begin_access(8'h80);
        @(posedge core_clk);
        repeat (8) begin
            irq_in <= 1'($urandom);
            @(posedge core_clk);
            note(2'h1, {7'h00, irq_in});
        end
        u_host.end_access();
        @(posedge core_clk);
        $display("test interrupt path done");
        // Frame read: flag follows unread count, interrupts hidden
        irq_in <= 1'b1;
        trx_state <= FBRG_ST_RX_BASIC;
        pulse(5'b10000);
        u_host.begin_access(8'h20);
        @(posedge core_clk);
        note(2'h1, 8'h01);
        pulse(5'b01000);
        pulse(5'b01000);
        note(2'h1, 8'h00);
        u_host.read_byte(ok);
        u_host.read_byte(ok);
        repeat (4) @(posedge core_clk);
        note(2'h1, 8'h01);
        pulse(5'b00001);
        pulse(5'b01000);
        u_host.read_byte(ok);
        @(posedge core_clk);
        note(2'h1, 8'h01);
        irq_in <= 1'b0;
        u_host.end_access();
        @(posedge core_clk);
        note(2'h1, 8'h00);
        $display("test empty flag done");
        // Protection: arming per mode, host writes pass, both releases
        pulse(5'b00100);
        radio(8'h01);
        reg_wr(6'h0C, 8'hA0);
        reg_rd(6'h0C, 8'hA0);
        pulse(5'b00100);
        radio(8'h00);
        host_fb_wr <= 1'b1;
        note(2'h3, 8'h01);
        trx_state <= FBRG_ST_OTHER;
        @(posedge core_clk);
        trx_state <= FBRG_ST_RX_AACK;
        @(posedge core_clk);
        radio(8'h01);
        pulse(5'b00100);
        radio(8'h01);
        pulse(5'b00010);
        radio(8'h00);
        u_host.begin_access(8'h3F);
        u_host.end_access();
        @(posedge core_clk);
        radio(8'h01);
        $display("test protection done");
        wrap_up();
    end
endmodule
